// ### src/aomc_regs.svh
// Register offsets, field positions, reset values and sizes of the converter configuration block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef AOMC_REGS_SVH
`define AOMC_REGS_SVH

`define AOMC_ADDR_OFFSET_HOLD 8'h13
`define AOMC_ADDR_MODE_POWER 8'h14
`define AOMC_ADDR_FORMAT 8'h16
`define AOMC_ADDR_CUSTOM_LO 8'h18
`define AOMC_ADDR_CUSTOM_HI 8'h19

`define AOMC_BIT_OFFSET_HOLD 4
`define AOMC_BIT_OVERRIDE 7
`define AOMC_BIT_LVDS 5
`define AOMC_BIT_REF_EXT 3
`define AOMC_BIT_POWER_LO 0
`define AOMC_BIT_FORMAT 4
`define AOMC_BIT_BYTEWISE 3
`define AOMC_BIT_PATTERN_LO 0
`define AOMC_BIT_CUSTOM_LO 3
`define AOMC_BIT_CUSTOM_HI 0

`define AOMC_RESET_REG 8'h00
`define AOMC_FRAME_BITS 5'h10
`define AOMC_SAMPLE_W 11
`define AOMC_OFFSET_SHIFT 6
`define AOMC_TOGGLE_A 11'h555
`define AOMC_TOGGLE_B 11'h2AA
`define AOMC_PWR_NORMAL 3'h0
`define AOMC_PWR_OFF_A 3'h1
`define AOMC_PWR_OFF_B 3'h2
`define AOMC_PWR_OFF_AB 3'h3
`define AOMC_PWR_GLOBAL 3'h4
`define AOMC_PWR_STBY_A 3'h5
`define AOMC_PWR_STBY_B 3'h6
`define AOMC_PWR_COMBINED 3'h7
`define AOMC_PAT_NORMAL 3'h0
`define AOMC_PAT_ZEROS 3'h1
`define AOMC_PAT_ONES 3'h2
`define AOMC_PAT_TOGGLE 3'h3
`define AOMC_PAT_RAMP 3'h4
`define AOMC_PAT_CUSTOM 3'h5

`endif

// ### src/aomc_pkg.sv
// Types shared by the converter configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package aomc_pkg;

  // Configuration snapshot carried from the register domain to the sample domain
  typedef struct packed {
    logic offset_hold;
    logic override;
    logic lvds;
    logic ref_ext;
    logic [2:0] power;
    logic straight_bin;
    logic bytewise;
    logic [2:0] pattern;
    logic [10:0] custom;
  } aomc_cfg_t;

  // Double-data-rate halves of one sample lane; byte packing needs seven wires at the rising edge
  typedef struct packed {
    logic [6:0] rise;
    logic [5:0] fall;
  } aomc_ddr_t;

  typedef enum logic [1:0] {
    AOMC_SER_IDLE = 2'b01,
    AOMC_SER_SHIFT = 2'b10
  } aomc_ser_state_t;

endpackage

// ### src/aomc_cfg_sync.sv
// Handshake crossing of a configuration word from a source clock to a destination clock.
// Assumes both resets are synchronous and active low, each in its own domain.
`timescale 1ns/1ps
`default_nettype none

module aomc_cfg_sync #(
  parameter int W = 23
) (
  // Source side
  input wire logic clk_src,
  input wire logic rst_src_b,
  input wire logic [W-1:0] src_data,
  // Destination side
  input wire logic clk_dst,
  input wire logic rst_dst_b,
  output logic [W-1:0] dst_data
);

  logic [W-1:0] hold;
  logic req;
  logic ack_s1;
  logic ack_s2;
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic ack;

  wire idle = (req == ack_s2);
  wire changed = (src_data != hold);

  // Word is held stable while a request is outstanding
  always_ff @(posedge clk_src) begin
    if (!rst_src_b) begin
      hold <= '0;
      req <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
      if (idle && changed) begin
        hold <= src_data;
        req <= ~req;
      end
    end
  end

  always_ff @(posedge clk_dst) begin
    if (!rst_dst_b) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      ack <= 1'b0;
      dst_data <= '0;
    end else begin
      req_s1 <= req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      if (req_s2 != req_s3) begin
        dst_data <= hold;
        ack <= req_s2;
      end
    end
  end

endmodule

`default_nettype wire

// ### src/aomc_top.sv
// Mode, power and output formatting control of a dual-channel 11-bit sampling converter.
// Assumes a three-wire serial write port from a host and converter samples on the sample clock.
`timescale 1ns/1ps
`default_nettype none
`include "aomc_regs.svh"

module aomc_top (
  // Register domain
  input wire logic clk_sys,
  input wire logic rst_b,
  // Serial configuration pins
  input wire logic ser_enable_b,
  input wire logic ser_clk,
  input wire logic ser_data,
  // Sample domain
  input wire logic clk_smp,
  input wire logic [10:0] adc_a,
  input wire logic [10:0] adc_b,
  // Parallel mode pins
  input wire logic pin_lvds,
  input wire logic [2:0] pin_power,
  // Analog controls
  output logic ref_ext,
  output logic power_down,
  output logic standby_a,
  output logic standby_b,
  // Parallel outputs
  output logic [10:0] cmos_a,
  output logic [10:0] cmos_b,
  output logic cmos_a_en,
  output logic cmos_b_en,
  output logic cmos_sel_b,
  // Double-data-rate outputs
  output var aomc_pkg::aomc_ddr_t ddr_a,
  output var aomc_pkg::aomc_ddr_t ddr_b,
  output logic ddr_en,
  output logic out_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial pin synchronisers

  logic [2:0] sen_sync;
  logic [2:0] sclk_sync;
  logic [1:0] sdat_sync;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sen_sync <= 3'h7;
      sclk_sync <= 3'h0;
      sdat_sync <= 2'h0;
    end else begin
      sen_sync <= {sen_sync[1:0], ser_enable_b};
      sclk_sync <= {sclk_sync[1:0], ser_clk};
      sdat_sync <= {sdat_sync[0], ser_data};
    end
  end

  wire sen_low = ~sen_sync[1];
  wire sen_rise = sen_sync[1] & ~sen_sync[2];
  wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  wire sdat = sdat_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame: 8 address bits then 8 data bits, most significant first

  aomc_pkg::aomc_ser_state_t ser_state;
  aomc_pkg::aomc_ser_state_t next_ser_state;
  logic [15:0] shift;
  logic [4:0] bit_cnt;

  always_comb begin
    next_ser_state = ser_state;
    case (ser_state)
      aomc_pkg::AOMC_SER_IDLE: begin
        if (sen_low) begin
          next_ser_state = aomc_pkg::AOMC_SER_SHIFT;
        end
      end
      aomc_pkg::AOMC_SER_SHIFT: begin
        if (sen_rise) begin
          next_ser_state = aomc_pkg::AOMC_SER_IDLE;
        end
      end
      default: begin
        next_ser_state = aomc_pkg::AOMC_SER_IDLE;
      end
    endcase
  end

  wire in_frame = (ser_state == aomc_pkg::AOMC_SER_SHIFT);
  wire take_bit = in_frame && sen_low && sclk_rise && (bit_cnt != `AOMC_FRAME_BITS);
  wire frame_done = in_frame && sen_rise && (bit_cnt == `AOMC_FRAME_BITS);
  wire [7:0] wr_addr = shift[15:8];
  wire [7:0] wr_data = shift[7:0];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ser_state <= aomc_pkg::AOMC_SER_IDLE;
      shift <= 16'h0000;
      bit_cnt <= 5'h00;
    end else begin
      ser_state <= next_ser_state;
      if (!in_frame) begin
        bit_cnt <= 5'h00;
      end else if (take_bit) begin
        shift <= {shift[14:0], sdat};
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] reg_offset_hold_control;
  logic [7:0] reg_mode_and_power_control;
  logic [7:0] reg_output_format_and_pattern;
  logic [7:0] reg_custom_low;
  logic [7:0] reg_custom_high;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = frame_done && (addr == target);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_offset_hold_control <= `AOMC_RESET_REG;
      reg_mode_and_power_control <= `AOMC_RESET_REG;
      reg_output_format_and_pattern <= `AOMC_RESET_REG;
      reg_custom_low <= `AOMC_RESET_REG;
      reg_custom_high <= `AOMC_RESET_REG;
    end else begin
      if (hit(wr_addr, `AOMC_ADDR_OFFSET_HOLD)) begin
        reg_offset_hold_control <= wr_data;
      end
      if (hit(wr_addr, `AOMC_ADDR_MODE_POWER)) begin
        reg_mode_and_power_control <= wr_data;
      end
      if (hit(wr_addr, `AOMC_ADDR_FORMAT)) begin
        reg_output_format_and_pattern <= wr_data;
      end
      if (hit(wr_addr, `AOMC_ADDR_CUSTOM_LO)) begin
        reg_custom_low <= wr_data;
      end
      if (hit(wr_addr, `AOMC_ADDR_CUSTOM_HI)) begin
        reg_custom_high <= wr_data;
      end
    end
  end

  aomc_pkg::aomc_cfg_t cfg_sys;
  aomc_pkg::aomc_cfg_t cfg;

  assign cfg_sys.offset_hold = reg_offset_hold_control[`AOMC_BIT_OFFSET_HOLD];
  assign cfg_sys.override = reg_mode_and_power_control[`AOMC_BIT_OVERRIDE];
  assign cfg_sys.lvds = reg_mode_and_power_control[`AOMC_BIT_LVDS];
  assign cfg_sys.ref_ext = reg_mode_and_power_control[`AOMC_BIT_REF_EXT];
  assign cfg_sys.power = reg_mode_and_power_control[`AOMC_BIT_POWER_LO +: 3];
  assign cfg_sys.straight_bin = reg_output_format_and_pattern[`AOMC_BIT_FORMAT];
  assign cfg_sys.bytewise = reg_output_format_and_pattern[`AOMC_BIT_BYTEWISE];
  assign cfg_sys.pattern = reg_output_format_and_pattern[`AOMC_BIT_PATTERN_LO +: 3];
  assign cfg_sys.custom = {reg_custom_high[`AOMC_BIT_CUSTOM_HI +: 6], reg_custom_low[`AOMC_BIT_CUSTOM_LO +: 5]};

  ////////////////////////////////////////////////////////////////////////////
  // Sample domain reset and crossing

  logic [1:0] rst_smp_sync;
  wire rst_smp_b = rst_smp_sync[1];

  always_ff @(posedge clk_smp) begin
    rst_smp_sync <= {rst_smp_sync[0], rst_b};
  end

  aomc_cfg_sync #(
    .W($bits(aomc_pkg::aomc_cfg_t))
  ) u_cfg_sync (
    .clk_src(clk_sys),
    .rst_src_b(rst_b),
    .src_data(cfg_sys),
    .clk_dst(clk_smp),
    .rst_dst_b(rst_smp_b),
    .dst_data(cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode pins and effective mode

  logic [1:0] lvds_pin_sync;
  logic [5:0] power_pin_sync;

  always_ff @(posedge clk_smp) begin
    if (!rst_smp_b) begin
      lvds_pin_sync <= 2'h0;
      power_pin_sync <= 6'h00;
    end else begin
      lvds_pin_sync <= {lvds_pin_sync[0], pin_lvds};
      power_pin_sync <= {power_pin_sync[2:0], pin_power};
    end
  end

  wire eff_lvds = cfg.override ? cfg.lvds : lvds_pin_sync[1];
  wire [2:0] eff_power = cfg.override ? cfg.power : power_pin_sync[5:3];
  wire combined_channel_mode = (eff_power == `AOMC_PWR_COMBINED) && !eff_lvds;
  wire global_down = (eff_power == `AOMC_PWR_GLOBAL);
  wire a_quiet = (eff_power == `AOMC_PWR_OFF_A) || (eff_power == `AOMC_PWR_OFF_AB) ||
                 (eff_power == `AOMC_PWR_STBY_A) || global_down;
  wire b_quiet = (eff_power == `AOMC_PWR_OFF_B) || (eff_power == `AOMC_PWR_OFF_AB) ||
                 (eff_power == `AOMC_PWR_STBY_B) || global_down || combined_channel_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Offset correction per channel

  logic [10:0] est_a;
  logic [10:0] est_b;

  function automatic logic [10:0] track(input logic [10:0] est, input logic [10:0] smp);
    logic [11:0] diff;
    diff = {1'b0, smp} - {1'b0, est};
    track = est + 11'({{`AOMC_OFFSET_SHIFT{diff[11]}}, diff[11:`AOMC_OFFSET_SHIFT]});
  endfunction

  always_ff @(posedge clk_smp) begin
    if (!rst_smp_b) begin
      est_a <= 11'h400;
      est_b <= 11'h400;
    end else if (!cfg.offset_hold) begin
      est_a <= track(est_a, adc_a);
      est_b <= track(est_b, adc_b);
    end
  end

  // Converter codes are offset binary; a sample equal to the estimate maps to mid-scale 11'h400
  wire [10:0] corr_a = adc_a - est_a + 11'h400;
  wire [10:0] corr_b = adc_b - est_b + 11'h400;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generation and formatting

  logic [10:0] ramp;
  logic toggle_phase;
  logic mux_phase;

  always_ff @(posedge clk_smp) begin
    if (!rst_smp_b) begin
      ramp <= 11'h000;
      toggle_phase <= 1'b0;
      mux_phase <= 1'b0;
    end else begin
      ramp <= ramp + 11'h001;
      toggle_phase <= ~toggle_phase;
      mux_phase <= combined_channel_mode ? ~mux_phase : 1'b0;
    end
  end

  function automatic logic [10:0] shape(input logic [10:0] smp, input aomc_pkg::aomc_cfg_t c,
                                        input logic [10:0] rmp, input logic tog);
    logic [10:0] fmt;
    logic [10:0] raw;
    // Coding applies to converter samples only; check patterns leave as defined
    fmt = c.straight_bin ? smp : {~smp[10], smp[9:0]};
    case (c.pattern)
      `AOMC_PAT_NORMAL: raw = fmt;
      `AOMC_PAT_ZEROS: raw = 11'h000;
      `AOMC_PAT_ONES: raw = 11'h7FF;
      `AOMC_PAT_TOGGLE: raw = tog ? `AOMC_TOGGLE_B : `AOMC_TOGGLE_A;
      `AOMC_PAT_RAMP: raw = rmp;
      `AOMC_PAT_CUSTOM: raw = c.custom;
      default: raw = fmt;
    endcase
    shape = raw;
  endfunction

  function automatic aomc_pkg::aomc_ddr_t pack(input logic [10:0] w, input logic byte_mode);
    aomc_pkg::aomc_ddr_t p;
    if (byte_mode) begin
      p.rise = w[6:0];
      p.fall = {2'b00, w[10:7]};
    end else begin
      p.rise = {2'b00, w[9], w[7], w[5], w[3], w[1]};
      p.fall = {w[10], w[8], w[6], w[4], w[2], w[0]};
    end
    pack = p;
  endfunction

  wire [10:0] word_a = shape(corr_a, cfg, ramp, toggle_phase);
  wire [10:0] word_b = shape(corr_b, cfg, ramp, toggle_phase);
  wire [10:0] word_bus_a = (combined_channel_mode && mux_phase) ? word_b : word_a;

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  always_ff @(posedge clk_smp) begin
    if (!rst_smp_b) begin
      cmos_a <= 11'h000;
      cmos_b <= 11'h000;
      cmos_a_en <= 1'b0;
      cmos_b_en <= 1'b0;
      cmos_sel_b <= 1'b0;
      ddr_a <= '0;
      ddr_b <= '0;
      ddr_en <= 1'b0;
      ref_ext <= 1'b0;
      power_down <= 1'b0;
      standby_a <= 1'b0;
      standby_b <= 1'b0;
    end else begin
      cmos_a <= (!eff_lvds && !a_quiet) ? word_bus_a : 11'h000;
      cmos_b <= (!eff_lvds && !b_quiet) ? word_b : 11'h000;
      cmos_a_en <= !eff_lvds && !a_quiet;
      cmos_b_en <= !eff_lvds && !b_quiet;
      cmos_sel_b <= combined_channel_mode && mux_phase;
      ddr_a <= (eff_lvds && !a_quiet) ? pack(word_a, cfg.bytewise) : '0;
      ddr_b <= (eff_lvds && !b_quiet) ? pack(word_b, cfg.bytewise) : '0;
      ddr_en <= eff_lvds && !global_down;
      ref_ext <= cfg.ref_ext;
      power_down <= global_down;
      standby_a <= (eff_power == `AOMC_PWR_STBY_A);
      standby_b <= (eff_power == `AOMC_PWR_STBY_B);
    end
  end

  // Output strobe follows the sample clock; rising half leads
  assign out_strobe = clk_smp;

endmodule

`default_nettype wire

// ### tb/aomc_asserts.sv
// Port assertions for the converter configuration block.
// Assumes it is bound into aomc_top; rst_b qualifies both clock domains.
`timescale 1ns/1ps
`default_nettype none
module aomc_asserts (
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic clk_smp,
  input wire logic rst_b,
  // Watched outputs
  input wire logic power_down,
  input wire logic standby_a,
  input wire logic standby_b,
  input wire logic [10:0] cmos_a,
  input wire logic [10:0] cmos_b,
  input wire logic cmos_a_en,
  input wire logic cmos_b_en,
  input wire logic cmos_sel_b,
  input wire logic ddr_en,
  input wire aomc_pkg::aomc_ddr_t ddr_a,
  input wire logic out_strobe
);
  a_pdown_quiet: assert property (@(posedge clk_smp) disable iff (!rst_b)
    power_down |-> !cmos_a_en && !cmos_b_en && !ddr_en) else $error("outputs live in power down");
  a_stby_a_quiet: assert property (@(posedge clk_smp) disable iff (!rst_b)
    standby_a |-> !cmos_a_en && cmos_a == 11'h000) else $error("lane a live in standby");
  a_stby_b_quiet: assert property (@(posedge clk_smp) disable iff (!rst_b)
    standby_b |-> !cmos_b_en && cmos_b == 11'h000) else $error("lane b live in standby");
  a_state_single: assert property (@(posedge clk_smp) disable iff (!rst_b)
    $onehot0({power_down, standby_a, standby_b})) else $error("two power states at once");
  a_off_zero: assert property (@(posedge clk_smp) disable iff (!rst_b)
    !cmos_b_en |-> cmos_b == 11'h000) else $error("disabled lane b not zero");
  a_lvds_no_cmos: assert property (@(posedge clk_smp) disable iff (!rst_b)
    ddr_en |-> cmos_a == 11'h000 && cmos_b == 11'h000) else $error("parallel data during ddr");
  a_mix_alternate: assert property (@(posedge clk_smp) disable iff (!rst_b)
    cmos_sel_b |=> !cmos_sel_b) else $error("channel b sent twice in a row");
  a_mix_cmos_only: assert property (@(posedge clk_smp) disable iff (!rst_b)
    cmos_sel_b |-> !ddr_en && !cmos_b_en && cmos_a_en) else $error("combined mode lanes wrong");
  a_ddr_rise_launch: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $changed(ddr_a) |-> $rose(out_strobe)) else $error("ddr lane changed off the strobe rising edge");
  c_mix: cover property (@(posedge clk_smp) cmos_sel_b);
  c_pdown: cover property (@(posedge clk_smp) power_down);
  c_ddr: cover property (@(posedge clk_smp) ddr_en);
endmodule
bind aomc_top aomc_asserts i_asserts (.clk_sys(clk_sys), .clk_smp(clk_smp), .rst_b(rst_b),
  .power_down(power_down), .standby_a(standby_a), .standby_b(standby_b), .cmos_a(cmos_a),
  .cmos_b(cmos_b), .cmos_a_en(cmos_a_en), .cmos_b_en(cmos_b_en), .cmos_sel_b(cmos_sel_b),
  .ddr_en(ddr_en), .ddr_a(ddr_a), .out_strobe(out_strobe));
`default_nettype wire

// ### tb/aomc_capture.sv
// Capture side: rebuilds one sample word from the channel A DDR lane.
// Assumes both halves stand for a whole strobe period after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module aomc_capture (
  // Lane and strobe
  input wire logic out_strobe,
  input wire aomc_pkg::aomc_ddr_t ddr_a,
  input wire logic bytewise,
  // Rebuilt sample
  output logic [10:0] word
);
  // Both halves taken mid-period, clear of the launching edge
  always @(negedge out_strobe) begin
    if (bytewise) begin
      word <= {ddr_a.fall[3:0], ddr_a.rise};
    end else begin
      word <= {ddr_a.fall[5], ddr_a.rise[4], ddr_a.fall[4], ddr_a.rise[3], ddr_a.fall[3], ddr_a.rise[2],
        ddr_a.fall[2], ddr_a.rise[1], ddr_a.fall[1], ddr_a.rise[0], ddr_a.fall[0]};
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the converter configuration block.
// Assumes package, design, checker and capture model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic clk_smp = 1'b0;
  logic rst_b = 1'b0;
  logic ser_enable_b = 1'b1;
  logic ser_clk = 1'b0;
  logic ser_data = 1'b0;
  logic [10:0] adc_a = 11'h400;
  logic [10:0] adc_b = 11'h400;
  logic pin_lvds = 1'b0;
  logic [2:0] pin_power = 3'h0;
  logic bytewise = 1'b0;
  logic ref_ext, power_down, standby_a, standby_b, cmos_a_en, cmos_b_en, cmos_sel_b, ddr_en, out_strobe;
  logic [10:0] cmos_a, cmos_b, word, v0, cust;
  logic st;
  aomc_pkg::aomc_ddr_t ddr_a, ddr_b;
  integer seed = 4;
  integer bad_count = 0;
  integer compares = 0;
  integer i, j;
  wire [15:0] pwr_now = {11'h000, power_down, standby_a, standby_b, cmos_a_en, cmos_b_en};

  always #10 clk_sys = ~clk_sys;
  always #24 clk_smp = ~clk_smp;
  always @(negedge clk_smp) adc_b <= 11'($random(seed));

  aomc_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ser_enable_b(ser_enable_b), .ser_clk(ser_clk),
    .ser_data(ser_data), .clk_smp(clk_smp), .adc_a(adc_a), .adc_b(adc_b), .pin_lvds(pin_lvds),
    .pin_power(pin_power), .ref_ext(ref_ext), .power_down(power_down), .standby_a(standby_a),
    .standby_b(standby_b), .cmos_a(cmos_a), .cmos_b(cmos_b), .cmos_a_en(cmos_a_en), .cmos_b_en(cmos_b_en),
    .cmos_sel_b(cmos_sel_b), .ddr_a(ddr_a), .ddr_b(ddr_b), .ddr_en(ddr_en), .out_strobe(out_strobe));
  aomc_capture i_cap (.out_strobe(out_strobe), .ddr_a(ddr_a), .bytewise(bytewise), .word(word));

  ////////////////////////////////////////////////////////////////
  task automatic cyc(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic smp(input integer n);
    repeat (n) @(negedge clk_smp);
  endtask
  // One 16-bit write frame, address then data, MSB first
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {a, d};
    @(negedge clk_sys);
    ser_enable_b = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      ser_data = f[k];
      cyc(4);
      ser_clk = 1'b1;
      cyc(4);
      ser_clk = 1'b0;
    end
    cyc(4);
    ser_enable_b = 1'b1;
    ser_data = ~ser_data;
    cyc(8);
    smp(12);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // {power_down, standby_a, standby_b, cmos_a_en, cmos_b_en} per power code
  function automatic logic [15:0] exp_pwr(input logic [2:0] c);
    exp_pwr = {11'h000, c == 3'h4, c == 3'h5, c == 3'h6, c == 3'h0 || c == 3'h2 || c == 3'h6,
      c == 3'h0 || c == 3'h1 || c == 3'h5};
  endfunction
  function automatic logic [10:0] exp_pat(input logic [2:0] p, input logic [10:0] prev);
    case (p)
      3'h1: exp_pat = 11'h000;
      3'h2: exp_pat = 11'h7FF;
      3'h3: exp_pat = (prev == 11'h555) ? 11'h2AA : 11'h555;
      3'h4: exp_pat = prev + 11'h001;
      default: exp_pat = cust;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  initial begin
    smp(4);
    chk(pwr_now, 16'h0000);
    @(negedge clk_sys);
    rst_b = 1'b1;
    cyc(3);
    smp(6);
    for (i = 0; i < 7; i++) begin
      pin_power = 3'(i);
      smp(6);
      chk(pwr_now, exp_pwr(3'(i)));
    end
    pin_lvds = 1'b1;
    pin_power = 3'h0;
    smp(6);
    chk({15'h0000, ddr_en}, 16'h0001);
    $display("test pins done");
    for (i = 0; i < 7; i++) begin
      wr(8'h14, {4'h8, i[0], 3'(i)});
      chk(pwr_now, exp_pwr(3'(i)));
      chk({14'h0000, ref_ext, ddr_en}, {14'h0000, i[0], 1'b0});
    end
    $display("test override done");
    wr(8'h14, 8'h87);
    for (i = 0; i < 4; i++) begin
      st = cmos_sel_b;
      smp(1);
      chk({14'h0000, cmos_sel_b, cmos_b_en}, {14'h0000, ~st, 1'b0});
    end
    wr(8'h14, 8'hA7);
    chk({14'h0000, cmos_sel_b, ddr_en}, 16'h0001);
    $display("test combined done");
    cust = 11'($random(seed));
    wr(8'h18, {cust[4:0], 3'h0});
    wr(8'h19, {2'h0, cust[10:5]});
    wr(8'h14, 8'h80);
    for (i = 1; i < 6; i++) begin
      wr(8'h16, 8'(i));
      for (j = 0; j < 3; j++) begin
        v0 = cmos_a;
        smp(1);
        chk({5'h00, cmos_a}, {5'h00, exp_pat(3'(i), v0)});
      end
    end
    wr(8'h16, 8'h04);
    i = 0;
    while (cmos_a !== 11'h7FF && i < 2100) begin
      smp(1);
      i++;
    end
    if (i >= 2100) begin
      bad_count++;
      give_verdict();
    end
    chk({5'h00, cmos_a}, 16'h07FF);
    smp(1);
    chk({5'h00, cmos_a}, 16'h0000);
    $display("test patterns done");
    wr(8'h16, 8'h05);
    wr(8'h14, 8'hA0);
    chk({5'h00, word}, {5'h00, cust});
    bytewise = 1'b1;
    wr(8'h16, 8'h0D);
    chk({5'h00, word}, {5'h00, cust});
    wr(8'h14, 8'h80);
    chk({5'h00, cmos_a}, {5'h00, cust});
    $display("test packing done");
    wr(8'h16, 8'h10);
    chk({5'h00, cmos_a}, 16'h0400);
    wr(8'h16, 8'h00);
    chk({5'h00, cmos_a}, 16'h0000);
    wr(8'h16, 8'h10);
    wr(8'h13, 8'h10);
    adc_a = 11'h500;
    smp(40);
    chk({5'h00, cmos_a}, 16'h0500);
    wr(8'h13, 8'h00);
    smp(200);
    chk({15'h0000, cmos_a == 11'h500}, 16'h0000);
    $display("test offset done");
    give_verdict();
  end
endmodule
`default_nettype wire
